/* design/node_id_pkg.sv */
// Purpose: Shared types and constants for the node identifier strap decoder.
// Assumes: 20 MHz system clock; strap voltages arrive as millivolt samples.
// Notes: Register offsets are byte addresses on the plain register port.
package node_id_pkg;

    // Clock and timing.
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SETTLE_NS = 100000;
    localparam int unsigned SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FLASH_NS = 1000000000;
    localparam int unsigned FLASH_CYCLES_DEF = FLASH_NS / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_W = 12;
    localparam int unsigned FLASH_W = 25;

    // Strap interval boundaries in millivolts, ascending.
    localparam logic [11:0] MV_B1 = 12'd530;
    localparam logic [11:0] MV_B2 = 12'd1410;
    localparam logic [11:0] MV_B3 = 12'd2010;
    localparam logic [11:0] MV_B4 = 12'd2430;
    localparam logic [11:0] MV_B5 = 12'd2750;
    localparam logic [11:0] MV_B6 = 12'd3010;
    localparam logic [11:0] MV_B7 = 12'd3220;

    // Identifier values.
    localparam logic [8:0] ID_ALL_ZERO = 9'h0ff;
    localparam logic [15:0] ALIAS_NONE = 16'h0000;
    localparam int unsigned CAN_MODE_BIT = 7;

    // Register map, byte offsets.
    localparam logic [7:0] OFS_NODE_ID = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CODES = 8'h08;
    localparam logic [7:0] OFS_ALIAS = 8'h0c;
    localparam logic [7:0] OFS_CTRL = 8'h10;

    // Status and control field positions; control reset value.
    localparam int unsigned ST_READY = 0;
    localparam int unsigned ST_FROM_HW = 1;
    localparam int unsigned ST_VENDOR = 2;
    localparam int unsigned ST_LSS = 3;
    localparam int unsigned ST_CAN = 4;
    localparam int unsigned CTRL_NODE_ADDR = 0;
    localparam logic CTRL_RST = 1'b0;

    // Strap samples and their 3-bit codes.
    typedef struct packed {
        logic [11:0] high_mv;
        logic [11:0] middle_mv;
        logic [11:0] low_mv;
    } strap_mv_t;

    typedef struct packed {
        logic [2:0] high;
        logic [2:0] middle;
        logic [2:0] low;
    } strap_code_t;

    // Stored setup presented by setup memory.
    typedef struct packed {
        logic valid;
        logic hw_select;
        logic [7:0] node_id;
    } setup_t;

    typedef enum logic [1:0] {
        PH_SETTLE = 2'b00,
        PH_CAPTURE = 2'b01,
        PH_HOLD = 2'b10
    } phase_t;

    // Whole state of the decoder.
    typedef struct packed {
        phase_t phase;
        logic [SETTLE_W-1:0] settle_cnt;
        logic [FLASH_W-1:0] flash_cnt;
        logic led_green;
        logic ready;
        logic from_hw;
        logic is_can;
        logic vendor_mode;
        logic lss_inactive;
        logic [8:0] node_id;
        strap_code_t codes;
        logic node_addr_mode;
        logic [15:0] alias_val;
        logic [31:0] rd_data;
    } dec_state_t;

    localparam dec_state_t STATE_RST = '{
        phase: PH_SETTLE, settle_cnt: '0, flash_cnt: '0, led_green: 1'b0,
        ready: 1'b0, from_hw: 1'b0, is_can: 1'b0, vendor_mode: 1'b0,
        lss_inactive: 1'b0, node_id: '0, codes: '0, node_addr_mode: CTRL_RST,
        alias_val: ALIAS_NONE, rd_data: '0};

endpackage

/* design/strap_quantiser.sv */
// Purpose: Turns three strap voltages into three 3-bit interval codes.
// Assumes: Samples are millivolts, synchronous to the clock.
// Notes: Purely combinational; the caller registers the codes.
`timescale 1ns/1ps
module strap_quantiser
    import node_id_pkg::*;
(
    input wire strap_mv_t i_mv,
    output strap_code_t o_code
);

    // Maps one voltage onto its interval; a boundary belongs to the upper interval.
    function automatic logic [2:0] quantise(input logic [11:0] mv);
        logic [2:0] c;
        c = 3'h0;
        if (mv >= MV_B1) begin
            c = 3'h1;
        end
        if (mv >= MV_B2) begin
            c = 3'h2;
        end
        if (mv >= MV_B3) begin
            c = 3'h3;
        end
        if (mv >= MV_B4) begin
            c = 3'h4;
        end
        if (mv >= MV_B5) begin
            c = 3'h5;
        end
        if (mv >= MV_B6) begin
            c = 3'h6;
        end
        if (mv >= MV_B7) begin
            c = 3'h7;
        end
        return c;
    endfunction

    always_comb begin
        o_code.high = quantise(i_mv.high_mv);
        o_code.middle = quantise(i_mv.middle_mv);
        o_code.low = quantise(i_mv.low_mv);
    end

endmodule // strap_quantiser

/* design/node_id_strap_decoder.sv */
// Purpose: Forms the drive's node identifier from three straps or stored setup.
// Assumes: Strap samples and setup inputs are stable once reset is released.
// Notes: Result is captured once per reset and then held.
// Function
// - After every reset the three strap inputs are captured and the identifier is set from them or from stored setup.
// - Each strap voltage falls into one of eight intervals and becomes a 3-bit code.
// - Boundaries are 0.53, 1.41, 2.01, 2.43, 2.75, 3.01 and 3.22 V, codes rising from 000.
// - The hardware identifier is 64 times the high code plus 8 times the middle plus the low.
// - The top bit of the high code, identifier bit 8, is always taken as zero.
// - On the network variant all-zero straps give identifier 255 and station alias 0.
// - Straps are used when hardware select is set, the stored setup is invalid or the stored identifier is 0.
// - A software identifier of 1 to 255 is used after power-on when hardware is not chosen.
// - In node-address addressing on the network variant the station alias is loaded with any identifier other than 255.
// - On the CAN variant strap identifier bit 7 high picks the vendor CAN mode, low picks CANopen.
// - On the CAN variant only bits 0 to 6 of a strap identifier form the node number, at most 127.
// - On CAN all-zero straps give 255, CANopen, LSS inactive and a green LED that toggles each second.
`timescale 1ns/1ps
module node_id_strap_decoder
    import node_id_pkg::*;
#(
    parameter int unsigned FLASH_CYCLES = FLASH_CYCLES_DEF
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [11:0] i_strap_low_input,
    input wire logic [11:0] i_strap_middle_input,
    input wire logic [11:0] i_strap_high_input,
    input wire setup_t i_setup,
    input wire logic i_variant_can,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [31:0] o_rd_data,
    output logic [8:0] o_node_identifier,
    output logic [15:0] o_station_alias,
    output logic o_vendor_can_protocol_mode,
    output logic o_lss_inactive,
    output logic o_led_green,
    output logic o_id_ready
);

    dec_state_t q_r;
    dec_state_t q_nxt;
    strap_mv_t strap_mv;
    strap_code_t strap_code;

    // Gathers the three samples into one carrier.
    assign strap_mv.high_mv = i_strap_high_input;
    assign strap_mv.middle_mv = i_strap_middle_input;
    assign strap_mv.low_mv = i_strap_low_input;

    // Shared quantiser for all three straps.
    strap_quantiser u_quant (
        .i_mv(strap_mv),
        .o_code(strap_code)
    );

    // Builds the raw hardware identifier; bit 8 is forced low.
    function automatic logic [8:0] hw_ident(input strap_code_t c);
        logic [8:0] v;
        v = {c.high, c.middle, c.low};
        v[8] = 1'b0;
        return v;
    endfunction

    // True when every strap sits in the lowest interval.
    function automatic logic all_zero(input strap_code_t c);
        return (c == '0);
    endfunction

    // Station alias follows the identifier only in node-address mode.
    function automatic logic [15:0] alias_of(input logic [8:0] id, input logic mode);
        logic [15:0] a;
        a = ALIAS_NONE;
        if (mode && (id != ID_ALL_ZERO)) begin
            a = {7'h00, id};
        end
        return a;
    endfunction

    // Next-state logic for capture, hold, LED flash and register port.
    always_comb begin
        logic use_hw;
        logic [8:0] id;
        logic is_zero;
        use_hw = 1'b0;
        id = '0;
        is_zero = 1'b0;
        q_nxt = q_r;
        q_nxt.rd_data = '0;

        unique case (q_r.phase)
            PH_SETTLE: begin
                // Lets the strap dividers settle before sampling.
                if (q_r.settle_cnt == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                    q_nxt.phase = PH_CAPTURE;
                end else begin
                    q_nxt.settle_cnt = q_r.settle_cnt + SETTLE_W'(1);
                end
            end
            PH_CAPTURE: begin
                q_nxt.codes = strap_code;
                q_nxt.is_can = i_variant_can;
                use_hw = i_setup.hw_select || !i_setup.valid || (i_setup.node_id == 8'h00);
                is_zero = use_hw && all_zero(strap_code);
                if (use_hw) begin
                    id = hw_ident(strap_code);
                end else begin
                    id = {1'b0, i_setup.node_id};
                end
                q_nxt.from_hw = use_hw;
                if (is_zero) begin
                    q_nxt.node_id = ID_ALL_ZERO;
                    q_nxt.vendor_mode = 1'b0;
                    q_nxt.lss_inactive = i_variant_can;
                end else if (i_variant_can && use_hw) begin
                    q_nxt.vendor_mode = id[CAN_MODE_BIT];
                    q_nxt.node_id = {2'b00, id[6:0]};
                    q_nxt.lss_inactive = 1'b0;
                end else begin
                    q_nxt.node_id = id;
                    q_nxt.vendor_mode = 1'b0;
                    q_nxt.lss_inactive = i_variant_can && (id == ID_ALL_ZERO);
                end
                q_nxt.ready = 1'b1;
                q_nxt.phase = PH_HOLD;
            end
            PH_HOLD: begin
                q_nxt.phase = PH_HOLD;
            end
            default: begin
                q_nxt.phase = PH_SETTLE;
            end
        endcase

        if (q_r.lss_inactive) begin
            if (q_r.flash_cnt >= FLASH_W'(FLASH_CYCLES - 1)) begin
                q_nxt.flash_cnt = '0;
                q_nxt.led_green = !q_r.led_green;
            end else begin
                q_nxt.flash_cnt = q_r.flash_cnt + FLASH_W'(1);
            end
        end

        // Control register write; other offsets ignore writes.
        if (i_wr_en && (i_addr == OFS_CTRL)) begin
            q_nxt.node_addr_mode = i_wr_data[CTRL_NODE_ADDR];
        end

        if (q_r.ready && !q_r.is_can) begin
            q_nxt.alias_val = alias_of(q_r.node_id, q_r.node_addr_mode);
        end else begin
            q_nxt.alias_val = ALIAS_NONE;
        end

        // Read data appears in the cycle after the strobe; unmapped reads give zero.
        if (i_rd_en) begin
            unique case (i_addr)
                OFS_NODE_ID: begin
                    q_nxt.rd_data = {23'h000000, q_r.node_id};
                end
                OFS_STATUS: begin
                    q_nxt.rd_data[ST_READY] = q_r.ready;
                    q_nxt.rd_data[ST_FROM_HW] = q_r.from_hw;
                    q_nxt.rd_data[ST_VENDOR] = q_r.vendor_mode;
                    q_nxt.rd_data[ST_LSS] = q_r.lss_inactive;
                    q_nxt.rd_data[ST_CAN] = q_r.is_can;
                end
                OFS_CODES: begin
                    q_nxt.rd_data = {23'h000000, q_r.codes};
                end
                OFS_ALIAS: begin
                    q_nxt.rd_data = {16'h0000, q_r.alias_val};
                end
                OFS_CTRL: begin
                    q_nxt.rd_data[CTRL_NODE_ADDR] = q_r.node_addr_mode;
                end
                default: begin
                    q_nxt.rd_data = '0;
                end
            endcase
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            q_r <= STATE_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    // All outputs come straight from the state register.
    assign o_rd_data = q_r.rd_data;
    assign o_node_identifier = q_r.node_id;
    assign o_station_alias = q_r.alias_val;
    assign o_vendor_can_protocol_mode = q_r.vendor_mode;
    assign o_lss_inactive = q_r.lss_inactive;
    assign o_led_green = q_r.led_green;
    assign o_id_ready = q_r.ready;

endmodule // node_id_strap_decoder

/* verification/node_id_sva.sv */
// Purpose: Port assertions for the strap decoder.
// Assumes: Variant input changes only while reset is held.
// Notes: Bound to the decoder after the module.
`timescale 1ns/1ps
module node_id_sva
    import node_id_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_variant_can,
    input wire logic [7:0] i_addr,
    input wire logic i_rd_en,
    input wire logic [31:0] o_rd_data,
    input wire logic [8:0] o_node_identifier,
    input wire logic [15:0] o_station_alias,
    input wire logic o_vendor_can_protocol_mode,
    input wire logic o_lss_inactive,
    input wire logic o_led_green,
    input wire logic o_id_ready
);
    // Counts edges since reset release and saturates.
    logic [11:0] cnt_r;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cnt_r <= 12'h000;
        end else if (cnt_r != 12'hfff) begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // Capture time, read port, hold and variant relations.
    ready_time_a: assert property ($rose(o_id_ready) |-> cnt_r >= 12'h7d1 && cnt_r <= 12'h7d3)
        else $error("ready at wrong cycle");
    ready_late_a: assert property (cnt_r == 12'h7da |-> o_id_ready)
        else $error("ready missing");
    rd_idle_a: assert property (!$past(i_rd_en) |-> o_rd_data == 32'h0)
        else $error("read data outside slot");
    id_read_a: assert property ($past(i_rd_en && i_addr == OFS_NODE_ID && o_id_ready)
        |-> o_rd_data == {23'h0, o_node_identifier}) else $error("id read wrong");
    id_held_a: assert property ($past(o_id_ready) |-> o_id_ready
        && $stable(o_node_identifier) && $stable(o_vendor_can_protocol_mode))
        else $error("result not held");
    bit_eight_a: assert property (o_node_identifier[8] == 1'b0)
        else $error("bit 8 set");
    vendor_id_a: assert property (o_vendor_can_protocol_mode |-> i_variant_can
        && o_node_identifier <= 9'h07f) else $error("vendor mode id wrong");
    lss_mode_a: assert property (o_lss_inactive |-> o_node_identifier == 9'h0ff
        && !o_vendor_can_protocol_mode) else $error("lss state wrong");
    alias_id_a: assert property (o_station_alias != 16'h0 |-> !i_variant_can
        && o_station_alias == {7'h0, o_node_identifier}) else $error("alias wrong");
    alias_none_a: assert property (o_node_identifier == 9'h0ff |-> o_station_alias == 16'h0)
        else $error("alias not zero");
    led_quiet_a: assert property (!o_lss_inactive |-> !o_led_green)
        else $error("led lit outside lss");

    // Main scenarios reached.
    cv_ready: cover property ($rose(o_id_ready));
    cv_vendor: cover property (o_vendor_can_protocol_mode);
    cv_led: cover property ($rose(o_led_green));
endmodule // node_id_sva

bind node_id_strap_decoder node_id_sva u_node_id_sva (.i_clk_sys, .i_rst_n, .i_variant_can,
    .i_addr, .i_rd_en, .o_rd_data, .o_node_identifier, .o_station_alias,
    .o_vendor_can_protocol_mode, .o_lss_inactive, .o_led_green, .o_id_ready);

/* verification/strap_divider_model.sv */
// Purpose: Resistive divider straps at the three identifier pins.
// Assumes: Levels are given in millivolts.
// Notes: i_top picks the top of each interval, else its lower bound.
`timescale 1ns/1ps
module strap_divider_model
    import node_id_pkg::*;
(
    input wire strap_code_t i_code,
    input wire logic i_top,
    output strap_mv_t o_mv
);
    localparam logic [11:0] LO_MV [9] = '{12'h000, 12'h212, 12'h582, 12'h7da, 12'h97e,
        12'habe, 12'hbc2, 12'hc94, 12'hce4};

    function automatic logic [11:0] lvl(input logic [2:0] c, input logic t);
        return t ? LO_MV[{1'b0, c} + 4'h1] - 12'h001 : LO_MV[c];
    endfunction

    // Drives each pin from its code.
    assign o_mv = '{lvl(i_code.high, i_top), lvl(i_code.middle, i_top), lvl(i_code.low, i_top)};
endmodule // strap_divider_model

/* verification/node_id_strap_decoder_tb.sv */
// Purpose: Self-checking bench for the strap decoder.
// Assumes: Straps come from the divider model; flash count cut to 8.
// Notes: Each scenario resets the block and waits for capture.
`timescale 1ns/1ps
module node_id_strap_decoder_tb
    import node_id_pkg::*;
;
    localparam int FL = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    strap_code_t code = '0;
    logic top = 1'b0;
    strap_mv_t mv;
    setup_t setup = '0;
    logic can = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [8:0] id;
    logic [15:0] st_alias;
    logic vend, lss, led, rdy;
    int bad_count = 0;
    int n_checks = 0;

    // Clock of 50 ns.
    initial begin
        forever #25 clk = ~clk;
    end

    strap_divider_model u_strap_divider_model (.i_code(code), .i_top(top), .o_mv(mv));
    node_id_strap_decoder #(.FLASH_CYCLES(FL)) u_node_id_strap_decoder (.i_clk_sys(clk),
        .i_rst_n(rst_n), .i_strap_low_input(mv.low_mv), .i_strap_middle_input(mv.middle_mv),
        .i_strap_high_input(mv.high_mv), .i_setup(setup), .i_variant_can(can), .i_addr(addr),
        .i_wr_data(wdata), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata),
        .o_node_identifier(id), .o_station_alias(st_alias), .o_vendor_can_protocol_mode(vend),
        .o_lss_inactive(lss), .o_led_green(led), .o_id_ready(rdy));

    // Compares a settled result with its expected value and counts any mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Resets with given straps and setup, then waits for capture.
    task automatic boot(input strap_code_t c, input logic t, input logic v, input setup_t s);
        int n;
        // Starts on a clock edge so every input change lands just after it.
        @(posedge clk);
        rst_n <= 1'b0;
        code <= c;
        top <= t;
        can <= v;
        setup <= s;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        n = 0;
        while (rdy !== 1'b1 && n < 2100) begin
            @(posedge clk);
            n++;
        end
        chk(32'(rdy), 32'h1);
        repeat (2) @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        // Read data stand only in this cycle; look once the edge has settled.
        #1;
        chk(rdata, exp);
        @(posedge clk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic t_sweep();
        strap_code_t c;
        logic [8:0] e;
        for (int i = 0; i < 16; i++) begin
            c = '{i[3:1], i[3:1] + 3'h3, 3'h7 - i[3:1]};
            e = (9'h040 * c.high + 9'h008 * c.middle + c.low) & 9'h0ff;
            boot(c, i[0], 1'b0, '{1'b1, 1'b1, 8'h01});
            chk(32'(id), 32'(e));
            rd_chk(OFS_CODES, {23'h0, c});
            wr_reg(OFS_CTRL, 32'h1);
            repeat (2) @(posedge clk);
            chk(32'(st_alias), 32'(e));
        end
        $display("sweep done");
    endtask

    task automatic t_zero_net();
        boot('0, 1'b0, 1'b0, '{1'b1, 1'b1, 8'h01});
        wr_reg(OFS_CTRL, 32'h1);
        rd_chk(OFS_NODE_ID, 32'h0ff);
        rd_chk(OFS_STATUS, 32'h3);
        rd_chk(8'h20, 32'h0);
        chk(32'(st_alias), 32'h0);
        $display("zero net done");
    endtask

    task automatic t_zero_can();
        int n;
        boot('0, 1'b1, 1'b1, '{1'b0, 1'b0, 8'h00});
        chk(32'({vend, lss, id}), 32'h2ff);
        n = 0;
        while (led !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 0;
        while (led === 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, FL);
        $display("zero can done");
    endtask

    task automatic t_can_mode();
        boot('{3'h2, 3'h5, 3'h3}, 1'b0, 1'b1, '{1'b1, 1'b1, 8'h01});
        chk(32'({vend, lss, id}), 32'h42b);
        boot('{3'h1, 3'h7, 3'h7}, 1'b1, 1'b1, '{1'b1, 1'b1, 8'h01});
        chk(32'({vend, lss, id}), 32'h07f);
        $display("can mode done");
    endtask

    task automatic t_soft();
        boot('{3'h1, 3'h2, 3'h3}, 1'b0, 1'b0, '{1'b1, 1'b0, 8'h9c});
        chk(32'(id), 32'h09c);
        code <= '{3'h6, 3'h6, 3'h6};
        setup <= '{1'b1, 1'b1, 8'h01};
        repeat (4) @(posedge clk);
        chk(32'(id), 32'h09c);
        rd_chk(OFS_STATUS, 32'h1);
        boot('{3'h1, 3'h2, 3'h3}, 1'b0, 1'b0, '{1'b0, 1'b0, 8'h9c});
        chk(32'(id), 32'h053);
        $display("soft done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Runs the scenarios.
    initial begin
        t_sweep();
        t_zero_net();
        t_zero_can();
        t_can_mode();
        t_soft();
        print_verdict();
    end

    // Cuts a hang short; the run needs about 44400 cycles.
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule // node_id_strap_decoder_tb
